// ---- sac_params.svh ----
/*
 * Constants of the speakerphone attenuation controller: register offsets,
 * reset values, range limits and timing figures.
 * Assumes it is included by bare name wherever a figure is needed.
 */
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_CLK_HZ        200000000
`define SAC_SAMPLE_HZ     8000
`define SAC_MS_PER_S      1000
`define SAC_WAIT_STEP_MS  16

`define SAC_OFF_LOSS      12'h000
`define SAC_OFF_DECAY     12'h004
`define SAC_OFF_SWITCH    12'h008
`define SAC_OFF_WAIT      12'h00C
`define SAC_OFF_AVG_STC   12'h010
`define SAC_OFF_AVG_NTC   12'h014
`define SAC_OFF_OFFSET    12'h018
`define SAC_OFF_CHG_LIM   12'h01C
`define SAC_OFF_STATUS    12'h020
`define SAC_OFF_CMD       12'h024
`define SAC_OFF_AGC_RD    12'h028

`define SAC_LOSS_MAX      8'h5F
`define SAC_OFFSET_MAX    8'h32
`define SAC_LIMIT_MAX     8'h5F

`define SAC_RST_LOSS      8'h30
`define SAC_RST_DECAY     8'h10
`define SAC_RST_SWITCH    8'hF0
`define SAC_RST_WAIT      8'h0F
`define SAC_RST_AVG_STC   8'hC0
`define SAC_RST_AVG_NTC   8'h20
`define SAC_RST_OFFSET    8'h0C
`define SAC_RST_CHG_LIM   8'h40

`define SAC_FRAC_BITS     4
`define SAC_CMD_SNAP_BIT  0

`endif

// ---- sac_pkg.sv ----
/*
 * Types shared by the speakerphone attenuation controller files.
 * Assumes sac_params.svh is on the include path.
 */
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_TX   = 2'b01,
        SAC_RX   = 2'b10
    } sac_state_t;

    function automatic logic [7:0] sac_sat8(input logic [7:0] v,
                                            input logic [7:0] max);
        sac_sat8 = (v > max) ? max : v;
    endfunction : sac_sat8

endpackage : sac_pkg

// ---- sac_speech_det.sv ----
/*
 * Speech detector for one direction: noise averaging filter, offset stage
 * and noise monitor comparator, updated once per audio sample.
 * Assumes the level input is a log level in dB on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sac_params.svh"

module sac_speech_det
    import sac_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sample_en,
    input  wire logic [7:0] level,
    input  wire logic [7:0] avg_speech_tc,
    input  wire logic [7:0] avg_noise_tc,
    input  wire logic [7:0] level_offset,
    input  wire logic [7:0] avg_charge_limit,
    output logic            speech
);

    // A longer time constant gives a deeper shift, so a slower filter.
    function automatic logic [3:0] tc_shift(input logic [7:0] tc);
        logic [3:0] s;
        s = 4'h1;
        for (int i = 0; i < 8; i++) begin
            if (tc[i]) begin
                s = 4'(i + 1);
            end
        end
        tc_shift = s;
    endfunction : tc_shift

    logic [15:0]        avg_q, avg_d;
    logic               speech_q, speech_d;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic [8:0]         thresh;
    logic [3:0]         sh;

    always_comb begin
        avg_d    = avg_q;
        speech_d = speech_q;
        diff     = $signed({1'b0, level, 8'h00}) - $signed({1'b0, avg_q});
        thresh   = {1'b0, avg_q[15:8]} + {1'b0, level_offset};
        sh       = speech_q ? tc_shift(avg_speech_tc)
                            : tc_shift(avg_noise_tc);
        step     = diff >>> sh;
        if (sample_en) begin
            speech_d = ({1'b0, level} > thresh);
            if (!(speech_q && avg_q[15:8] >= avg_charge_limit)) begin
                avg_d = 16'($signed({1'b0, avg_q}) + step);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avg_q    <= 16'h0000;
            speech_q <= 1'b0;
        end else begin
            avg_q    <= avg_d;
            speech_q <= speech_d;
        end
    end

    assign speech = speech_q;

endmodule : sac_speech_det
`default_nettype wire

// ---- sac_attn_ctrl.sv ----
/*
 * Speakerphone attenuation controller: APB register file, sample and
 * millisecond dividers, two speech detectors, the three-state voice
 * switch and the loss ramp that drives both attenuation stages.
 * Assumes level, comparator and gain inputs come from logic on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sac_params.svh"

module sac_attn_ctrl
    import sac_pkg::*;
#(
    parameter int SAMPLE_DIV = `SAC_CLK_HZ / `SAC_SAMPLE_HZ,
    parameter int MS_DIV     = `SAC_CLK_HZ / `SAC_MS_PER_S
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  tx_level,
    input  wire logic [7:0]  rx_level,
    input  wire logic        acoustic_side_comparator,
    input  wire logic        line_side_comparator,
    input  wire logic [7:0]  tx_auto_gain,
    input  wire logic [7:0]  rx_auto_gain,
    output logic      [11:0] tx_loss_stage,
    output logic      [11:0] rx_loss_stage,
    output logic      [1:0]  speaker_state_field
);

    if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535) begin : g_chk_sample
        $error("SAMPLE_DIV out of range");
    end
    if (MS_DIV < 2 || MS_DIV > 262143) begin : g_chk_ms
        $error("MS_DIV out of range");
    end

    localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_DIV - 1);
    localparam logic [17:0] MS_LAST     = 18'(MS_DIV - 1);

    // Dividers: one-cycle enables for the sample rate and for milliseconds.
    logic [15:0] scnt_q, scnt_d;
    logic [17:0] mcnt_q, mcnt_d;
    logic        sample_en, ms_en;

    assign sample_en = (scnt_q == SAMPLE_LAST);
    assign ms_en     = (mcnt_q == MS_LAST);

    always_comb begin
        scnt_d = sample_en ? 16'h0000 : scnt_q + 16'h0001;
        mcnt_d = ms_en ? 18'h00000 : mcnt_q + 18'h00001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scnt_q <= 16'h0000;
            mcnt_q <= 18'h00000;
        end else begin
            scnt_q <= scnt_d;
            mcnt_q <= mcnt_d;
        end
    end

    // Register file.
    logic [7:0]  loss_q, loss_d;
    logic [7:0]  decay_q, decay_d;
    logic [7:0]  switch_q, switch_d;
    logic [7:0]  wait_q, wait_d;
    logic [7:0]  stc_q, stc_d;
    logic [7:0]  ntc_q, ntc_d;
    logic [7:0]  offs_q, offs_d;
    logic [7:0]  clim_q, clim_d;
    logic [7:0]  agc_snap_q, agc_snap_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        access, commit, mapped, ro_hit;
    logic [31:0] rd_mux;
    sac_state_t  state_q, state_d;
    logic        tx_speech, rx_speech;

    assign access = psel && penable && !pready_q;
    assign commit = psel && penable && pready_q;

    always_comb begin
        mapped = 1'b1;
        ro_hit = 1'b0;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `SAC_OFF_LOSS:    rd_mux[7:0] = loss_q;
            `SAC_OFF_DECAY:   rd_mux[7:0] = decay_q;
            `SAC_OFF_SWITCH:  rd_mux[7:0] = switch_q;
            `SAC_OFF_WAIT:    rd_mux[7:0] = wait_q;
            `SAC_OFF_AVG_STC: rd_mux[7:0] = stc_q;
            `SAC_OFF_AVG_NTC: rd_mux[7:0] = ntc_q;
            `SAC_OFF_OFFSET:  rd_mux[7:0] = offs_q;
            `SAC_OFF_CHG_LIM: rd_mux[7:0] = clim_q;
            `SAC_OFF_STATUS: begin
                rd_mux[3:0] = {rx_speech, tx_speech, state_q};
                ro_hit      = 1'b1;
            end
            `SAC_OFF_CMD:     rd_mux = 32'h0000_0000;
            `SAC_OFF_AGC_RD: begin
                rd_mux[7:0] = agc_snap_q;
                ro_hit      = 1'b1;
            end
            default:          mapped = 1'b0;
        endcase
    end

    always_comb begin
        loss_d     = loss_q;
        decay_d    = decay_q;
        switch_d   = switch_q;
        wait_d     = wait_q;
        stc_d      = stc_q;
        ntc_d      = ntc_q;
        offs_d     = offs_q;
        clim_d     = clim_q;
        agc_snap_d = agc_snap_q;
        prdata_d   = prdata_q;
        pready_d   = access;
        pslverr_d  = access && (!mapped || (pwrite && ro_hit));
        if (access && !pwrite) begin
            prdata_d = rd_mux;
        end
        if (commit && pwrite && mapped) begin
            unique case (paddr)
                `SAC_OFF_LOSS:    loss_d   = sac_sat8(pwdata[7:0], `SAC_LOSS_MAX);
                `SAC_OFF_DECAY:   decay_d  = pwdata[7:0];
                `SAC_OFF_SWITCH:  switch_d = pwdata[7:0];
                `SAC_OFF_WAIT:    wait_d   = pwdata[7:0];
                `SAC_OFF_AVG_STC: stc_d    = pwdata[7:0];
                `SAC_OFF_AVG_NTC: ntc_d    = pwdata[7:0];
                `SAC_OFF_OFFSET:  offs_d   = sac_sat8(pwdata[7:0], `SAC_OFFSET_MAX);
                `SAC_OFF_CHG_LIM: clim_d   = sac_sat8(pwdata[7:0], `SAC_LIMIT_MAX);
                `SAC_OFF_CMD: begin
                    if (pwdata[`SAC_CMD_SNAP_BIT]) begin
                        agc_snap_d = rx_auto_gain;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_q     <= `SAC_RST_LOSS;
            decay_q    <= `SAC_RST_DECAY;
            switch_q   <= `SAC_RST_SWITCH;
            wait_q     <= `SAC_RST_WAIT;
            stc_q      <= `SAC_RST_AVG_STC;
            ntc_q      <= `SAC_RST_AVG_NTC;
            offs_q     <= `SAC_RST_OFFSET;
            clim_q     <= `SAC_RST_CHG_LIM;
            agc_snap_q <= 8'h00;
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
        end else begin
            loss_q     <= loss_d;
            decay_q    <= decay_d;
            switch_q   <= switch_d;
            wait_q     <= wait_d;
            stc_q      <= stc_d;
            ntc_q      <= ntc_d;
            offs_q     <= offs_d;
            clim_q     <= clim_d;
            agc_snap_q <= agc_snap_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // Speech detectors share one parameter set for both directions.
    sac_speech_det u_tx_det (
        .pclk             (pclk),
        .presetn          (presetn),
        .sample_en        (sample_en),
        .level            (tx_level),
        .avg_speech_tc    (stc_q),
        .avg_noise_tc     (ntc_q),
        .level_offset     (offs_q),
        .avg_charge_limit (clim_q),
        .speech           (tx_speech)
    );

    sac_speech_det u_rx_det (
        .pclk             (pclk),
        .presetn          (presetn),
        .sample_en        (sample_en),
        .level            (rx_level),
        .avg_speech_tc    (stc_q),
        .avg_noise_tc     (ntc_q),
        .level_offset     (offs_q),
        .avg_charge_limit (clim_q),
        .speech           (rx_speech)
    );

    // Voice switch. Idle is entered only once the wait time has run out
    // without any speech, so short pauses do not start a decay.
    // Just as wide as the longest count needs, so a wait code of 255 (4096 ms)
    // is neither truncated to zero nor out of the counter's reach.
    logic [12:0] wcnt_q, wcnt_d;
    logic        decaying_q, decaying_d;
    logic        tx_go, rx_go, quiet, wait_done;

    assign tx_go     = tx_speech && acoustic_side_comparator;
    assign rx_go     = rx_speech && line_side_comparator;
    assign quiet     = !tx_speech && !rx_speech;
    assign wait_done = (wcnt_q >= 13'(({5'h00, wait_q} + 13'h0001) * `SAC_WAIT_STEP_MS));

    always_comb begin
        state_d    = state_q;
        wcnt_d     = wcnt_q;
        decaying_d = decaying_q;
        if (!quiet) begin
            wcnt_d = 13'h0000;
        end else if (ms_en && !wait_done) begin
            wcnt_d = wcnt_q + 13'h0001;
        end
        unique case (state_q)
            SAC_IDLE, SAC_TX, SAC_RX: begin
                if (tx_go && state_q != SAC_TX) begin
                    state_d    = SAC_TX;
                    decaying_d = 1'b0;
                end else if (rx_go && !tx_go && state_q != SAC_RX) begin
                    state_d    = SAC_RX;
                    decaying_d = 1'b0;
                end else if (quiet && wait_done && state_q != SAC_IDLE) begin
                    state_d    = SAC_IDLE;
                    decaying_d = 1'b1;
                end
            end
            default: begin
                state_d    = SAC_IDLE;
                decaying_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= SAC_IDLE;
            wcnt_q     <= 13'h0000;
            decaying_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            wcnt_q     <= wcnt_d;
            decaying_q <= decaying_d;
        end
    end

    // Loss ramp in sixteenths of a dB; pos is the share on the receive path.
    logic [8:0]  gain_avg;
    logic [8:0]  eff_db;
    logic [11:0] span, target;
    logic [11:0] pos_q, pos_d;
    logic [7:0]  rcnt_q, rcnt_d;
    logic [11:0] step;
    logic [11:0] tx_loss_q, tx_loss_d;
    logic [11:0] rx_loss_q, rx_loss_d;
    logic [1:0]  sfield_q, sfield_d;

    always_comb begin
        gain_avg  = 9'(({1'b0, tx_auto_gain} + {1'b0, rx_auto_gain}) >> 1);
        eff_db    = {1'b0, loss_q} + gain_avg;
        if (eff_db > 9'h0FF) begin
            eff_db = 9'h0FF;
        end
        span      = {eff_db[7:0], 4'h0};
        unique case (state_q)
            SAC_TX:  target = span;
            SAC_RX:  target = 12'h000;
            default: target = {1'b0, span[11:1]};
        endcase
        pos_d     = pos_q;
        rcnt_d    = rcnt_q;
        step      = 12'h000;
        if (sample_en) begin
            if (decaying_q) begin
                if (rcnt_q >= decay_q) begin
                    rcnt_d = 8'h00;
                    step   = 12'h001;
                end else begin
                    rcnt_d = rcnt_q + 8'h01;
                end
            end else begin
                rcnt_d = 8'h00;
                step   = 12'h100 - {4'h0, switch_q};
            end
            if (pos_q < target) begin
                pos_d = (target - pos_q > step) ? pos_q + step : target;
            end else if (pos_q > target) begin
                pos_d = (pos_q - target > step) ? pos_q - step : target;
            end
        end
        rx_loss_d = (pos_q > span) ? span : pos_q;
        tx_loss_d = (pos_q > span) ? 12'h000 : span - pos_q;
        sfield_d  = state_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q     <= 12'h000;
            rcnt_q    <= 8'h00;
            tx_loss_q <= 12'h000;
            rx_loss_q <= 12'h000;
            sfield_q  <= 2'b00;
        end else begin
            pos_q     <= pos_d;
            rcnt_q    <= rcnt_d;
            tx_loss_q <= tx_loss_d;
            rx_loss_q <= rx_loss_d;
            sfield_q  <= sfield_d;
        end
    end

    assign tx_loss_stage       = tx_loss_q;
    assign rx_loss_stage       = rx_loss_q;
    assign speaker_state_field = sfield_q;

endmodule : sac_attn_ctrl
`default_nettype wire

// ---- sac_attn_ctrl_checker.sv ----
/*
 * Concurrent checks on the ports of the attenuation controller.
 * Assumes one clock, an asynchronous active-low reset and the bind below.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sac_params.svh"

module sac_attn_ctrl_checker
    import sac_pkg::*;
#(
    parameter int SAMPLE_DIV = 8,
    parameter int MS_DIV     = 16
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  tx_level,
    input wire logic [7:0]  rx_level,
    input wire logic        acoustic_side_comparator,
    input wire logic        line_side_comparator,
    input wire logic [7:0]  tx_auto_gain,
    input wire logic [7:0]  rx_auto_gain,
    input wire logic [11:0] tx_loss_stage,
    input wire logic [11:0] rx_loss_stage,
    input wire logic [1:0]  speaker_state_field
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_state_legal: assert property (speaker_state_field != 2'b11)
        else $error("state field holds the unused code");
    a_tx_entry: assert property ((speaker_state_field == SAC_TX)
        && ($past(speaker_state_field) != SAC_TX) |-> $past(acoustic_side_comparator)
        || $past(acoustic_side_comparator, 2) || $past(acoustic_side_comparator, 3))
        else $error("transmit entered without the acoustic comparator");
    a_rx_entry: assert property ((speaker_state_field == SAC_RX)
        && ($past(speaker_state_field) != SAC_RX) |-> $past(line_side_comparator)
        || $past(line_side_comparator, 2) || $past(line_side_comparator, 3))
        else $error("receive entered without the line comparator");
    a_loss_cap: assert property ((tx_loss_stage <= 12'hFF0) && (rx_loss_stage <= 12'hFF0))
        else $error("loss stage above the widest sweep");
    a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("bus answer not in the second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_ro_refused: assert property (psel && !penable && pwrite
        && (paddr == `SAC_OFF_STATUS || paddr == `SAC_OFF_AGC_RD) |-> ##2 pslverr)
        else $error("write to a read-only word not refused");
    a_unmapped_err: assert property (psel && !penable && (paddr > `SAC_OFF_AGC_RD)
        |-> ##2 pslverr)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data above the byte not zero");

    c_tx: cover property (speaker_state_field == SAC_TX);
    c_rx: cover property (speaker_state_field == SAC_RX);
    c_err: cover property (pslverr);
endmodule : sac_attn_ctrl_checker

bind sac_attn_ctrl sac_attn_ctrl_checker #(.SAMPLE_DIV(SAMPLE_DIV), .MS_DIV(MS_DIV)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_level(tx_level), .rx_level(rx_level),
    .acoustic_side_comparator(acoustic_side_comparator),
    .line_side_comparator(line_side_comparator), .tx_auto_gain(tx_auto_gain),
    .rx_auto_gain(rx_auto_gain), .tx_loss_stage(tx_loss_stage),
    .rx_loss_stage(rx_loss_stage), .speaker_state_field(speaker_state_field));
`default_nettype wire

// ---- sac_audio_model.sv ----
/*
 * Audio-side stand-in: levels, comparators and gains for both directions.
 * Assumes mode 0 silence, 1 near talk, 2 far talk, 3 near level only.
 */
`timescale 1ns/10ps
`default_nettype none

module sac_audio_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] gain,
    output logic      [7:0] tx_level,
    output logic      [7:0] rx_level,
    output logic            acoustic_cmp,
    output logic            line_cmp,
    output logic      [7:0] tx_gain,
    output logic      [7:0] rx_gain
);
    logic flip_q;

    // Silence wobbles between two low levels so a stuck sample path shows up.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flip_q       <= 1'b0;
            tx_level     <= 8'h00;
            rx_level     <= 8'h00;
            acoustic_cmp <= 1'b0;
            line_cmp     <= 1'b0;
            tx_gain      <= 8'h00;
            rx_gain      <= 8'h00;
        end else begin
            flip_q       <= !flip_q;
            tx_level     <= mode[0] ? 8'h60 : {5'h00, flip_q, 2'b00};
            rx_level     <= (mode == 2'd2) ? 8'h60 : {5'h00, !flip_q, 2'b00};
            acoustic_cmp <= (mode == 2'd1);
            line_cmp     <= (mode == 2'd2);
            tx_gain      <= gain;
            rx_gain      <= gain;
        end
    end
endmodule : sac_audio_model
`default_nettype wire

// ---- sac_attn_ctrl_bench.sv ----
/*
 * Self-checking bench for the attenuation controller over APB.
 * Assumes short divider parameters; losses are in sixteenths of a dB.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sac_params.svh"

module sac_attn_ctrl_bench
    import sac_pkg::*;
;
    localparam int LIMIT = 30000;
    localparam logic [11:0] OFFS [8] = '{`SAC_OFF_LOSS, `SAC_OFF_DECAY, `SAC_OFF_SWITCH,
        `SAC_OFF_WAIT, `SAC_OFF_AVG_STC, `SAC_OFF_AVG_NTC, `SAC_OFF_OFFSET, `SAC_OFF_CHG_LIM};
    localparam logic [7:0] RSTV [8] = '{`SAC_RST_LOSS, `SAC_RST_DECAY, `SAC_RST_SWITCH,
        `SAC_RST_WAIT, `SAC_RST_AVG_STC, `SAC_RST_AVG_NTC, `SAC_RST_OFFSET, `SAC_RST_CHG_LIM};
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, acmp, lcmp, er;
    logic [11:0] paddr, tx_loss, rx_loss;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  tx_level, rx_level, tx_gain, rx_gain, gain;
    logic [1:0]  state, mode;
    int          n_fail, total_checks, cyc, n;

    sac_attn_ctrl #(.SAMPLE_DIV(8), .MS_DIV(16)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_level(tx_level),
        .rx_level(rx_level), .acoustic_side_comparator(acmp), .line_side_comparator(lcmp),
        .tx_auto_gain(tx_gain), .rx_auto_gain(rx_gain), .tx_loss_stage(tx_loss),
        .rx_loss_stage(rx_loss), .speaker_state_field(state));
    sac_audio_model u_model (.pclk(pclk), .presetn(presetn), .mode(mode), .gain(gain),
        .tx_level(tx_level), .rx_level(rx_level), .acoustic_cmp(acmp), .line_cmp(lcmp),
        .tx_gain(tx_gain), .rx_gain(rx_gain));

    always #2.5 pclk = ~pclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
        apb(1'b1, a, {24'h000000, d});
        chk("write error flag", {31'h0, ee}, {31'h0, er});
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [7:0] d, input logic ee);
        apb(1'b0, a, 32'h0);
        chk("read error flag", {31'h0, ee}, {31'h0, er});
        if (!ee)
            chk("read data", {24'h000000, d}, rd);
    endtask : rdc

    task automatic status(input logic [1:0] s, input logic [1:0] sp);
        apb(1'b0, `SAC_OFF_STATUS, 32'h0);
        chk("status state", {30'h0, s}, {30'h0, rd[1:0]});
        chk("status speech", {30'h0, sp}, {30'h0, rd[3:2]});
    endtask : status

    task automatic wait_state(input logic [1:0] s, input int lim);
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("state field", {30'h0, s}, {30'h0, state});
    endtask : wait_state

    task automatic wait_loss(input logic [11:0] etx, input logic [11:0] erx, input int lim);
        n = 0;
        while ((tx_loss !== etx || rx_loss !== erx) && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("tx loss", {20'h0, etx}, {20'h0, tx_loss});
        chk("rx loss", {20'h0, erx}, {20'h0, rx_loss});
    endtask : wait_loss

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {mode, gain, n_fail, total_checks} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(OFFS[i], RSTV[i], 1'b0);
        wr(`SAC_OFF_LOSS, 8'h60, 1'b0);
        rdc(`SAC_OFF_LOSS, `SAC_LOSS_MAX, 1'b0);
        wr(`SAC_OFF_OFFSET, 8'h33, 1'b0);
        rdc(`SAC_OFF_OFFSET, `SAC_OFFSET_MAX, 1'b0);
        wr(`SAC_OFF_CHG_LIM, 8'h60, 1'b0);
        rdc(`SAC_OFF_CHG_LIM, `SAC_LIMIT_MAX, 1'b0);
        wr(`SAC_OFF_STATUS, 8'h03, 1'b1);
        rdc(12'h030, 8'h00, 1'b1);
        wr(`SAC_OFF_OFFSET, `SAC_RST_OFFSET, 1'b0);
        wr(`SAC_OFF_CHG_LIM, `SAC_RST_CHG_LIM, 1'b0);
        wr(`SAC_OFF_LOSS, 8'h14, 1'b0);
        wr(`SAC_OFF_DECAY, 8'h01, 1'b0);
        wr(`SAC_OFF_WAIT, 8'h00, 1'b0);
        $display("test registers done");
        wait_loss(12'h0A0, 12'h0A0, 6000);
        status(SAC_IDLE, 2'b00);
        mode <= 2'd2;
        wait_state(SAC_RX, 100);
        wait_loss(12'h140, 12'h000, 400);
        chk("switch ramp", 32'h1, {31'h0, n >= 56 && n <= 100});
        status(SAC_RX, 2'b10);
        $display("test receive done");
        mode <= 2'd3;
        repeat (150) @(posedge pclk);
        chk("state field", {30'h0, SAC_RX}, {30'h0, state});
        mode <= 2'd1;
        wait_state(SAC_TX, 100);
        wait_loss(12'h000, 12'h140, 400);
        status(SAC_TX, 2'b01);
        $display("test transmit done");
        gain <= 8'h0A;
        wait_loss(12'h000, 12'h1E0, 400);
        wr(`SAC_OFF_CMD, 8'h01, 1'b0);
        rdc(`SAC_OFF_AGC_RD, 8'h0A, 1'b0);
        gain <= 8'h00;
        wait_loss(12'h000, 12'h140, 400);
        $display("test gain done");
        mode <= 2'd0;
        repeat (200) @(posedge pclk);
        chk("state field", {30'h0, SAC_TX}, {30'h0, state});
        wait_state(SAC_IDLE, 400);
        wait_loss(12'h0A0, 12'h0A0, 4000);
        chk("decay ramp", 32'h1, {31'h0, n >= 2480 && n <= 2640});
        $display("test idle done");
        end_of_test();
    end
endmodule : sac_attn_ctrl_bench
`default_nettype wire
